// *** hw/hspl_map.vh ***
// constants for the hub strap latch and speed indicator block
`ifndef HSPL_MAP_VH
`define HSPL_MAP_VH

// ======================================================================
// register offsets (byte addresses, one word each)
`define HSPL_ADDR_STRAP 4'h0
`define HSPL_ADDR_CTRL 4'h4
`define HSPL_ADDR_IRQ_STAT 4'h8
`define HSPL_ADDR_IRQ_MASK 4'hC

// ======================================================================
// field layouts
`define HSPL_CTRL_STRAP_EN 0
`define HSPL_CTRL_HS 1
`define HSPL_CTRL_ACTIVE 2
`define HSPL_CTRL_RESET 3'h0
`define HSPL_IRQ_OC_LSB 0
`define HSPL_IRQ_OC_MSB 3
`define HSPL_IRQ_LATCH 4
`define HSPL_IRQ_RESET 5'h00

// ======================================================================
// fixed-port codes
`define HSPL_FIX_NONE 2'h0
`define HSPL_FIX_P1 2'h1
`define HSPL_FIX_P12 2'h2
`define HSPL_FIX_P123 2'h3

// ======================================================================
// synchroniser pin positions and idle levels
`define HSPL_PIN_COUNT 9
`define HSPL_PIN_EXT_RST 8
`define HSPL_PIN_STRAP_MSB 7
`define HSPL_PIN_STRAP_LSB 6
`define HSPL_PIN_SEL_MSB 5
`define HSPL_PIN_SEL_LSB 4
`define HSPL_PIN_OC_MSB 3
`define HSPL_PIN_OC_LSB 0
`define HSPL_PIN_IDLE 9'h00F

// ======================================================================
// timing: least external reset low time
`define HSPL_RST_MIN_NS 1000
`define HSPL_CLK_PERIOD_NS 10

`endif

// *** hw/hspl_top.v ***
// strap latch, indicator drive and over-current sense for a four-port hub
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "hspl_map.vh"

// the block watches the hub's reset-time pins. while the external reset
// pin is low every shared strap pin is an input; on its release the
// config selects and, when enabled, the fixed-port straps are captured
// once and then held. the two indicator levels follow software state in
// the control register, as the link logic that knows speed and suspend
// sits outside this block. over-current inputs are synchronised, shown
// active high and flag a sticky onset event per port.

// How it works
// - sample both fixed-port straps at reset release
// - decode fixed-port code into fixed port mask
// - latch both config selects at reset release
// - speed indicator polarity from latched select hi
// - indicator asserted at high speed, negated full
// - four active-low over-current inputs, one each
// - suspend indicator polarity from fixed-port code
module hspl_top (
	input wire clk_i,
	input wire rst_i,
	input wire ext_reset_n_i,
	input wire fixed_port_strap_hi_i,
	input wire fixed_port_strap_lo_i,
	input wire config_method_sel_lo_i,
	input wire config_method_sel_hi_i,
	input wire [3:0] port_overcurrent_sense_n_i,
	output reg upstream_speed_indicator_o,
	output reg upstream_speed_indicator_oe_o,
	output reg suspend_state_indicator_o,
	output reg suspend_state_indicator_oe_o,
	output reg [1:0] config_method_o,
	output reg [3:0] fixed_ports_o,
	output reg [3:0] port_overcurrent_o,
	output reg irq_o,
	input wire [3:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	input wire wb_we_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o
);

	// decode of the fixed-port code into the fixed_ports_o port mask; the strap word carries the raw code
	function [3:0] hspl_fixed_mask;
		input [1:0] code;
		begin
			case (code)
				`HSPL_FIX_NONE: hspl_fixed_mask = 4'h0;
				`HSPL_FIX_P1: hspl_fixed_mask = 4'h1;
				`HSPL_FIX_P12: hspl_fixed_mask = 4'h3;
				`HSPL_FIX_P123: hspl_fixed_mask = 4'h7;
				default: hspl_fixed_mask = 4'h0;
			endcase
		end
	endfunction

	// ======================================================================
	// three-stage synchronisers for every pin input
	// every stage resets to the pin's idle level, so no false release edge
	// or over-current onset is seen in the first cycles after reset
	localparam [8:0] PIN_IDLE = `HSPL_PIN_IDLE;
	wire [8:0] pin_stable;
	wire [8:0] pin_raw = {ext_reset_n_i, fixed_port_strap_hi_i, fixed_port_strap_lo_i,
		config_method_sel_hi_i, config_method_sel_lo_i, port_overcurrent_sense_n_i};

	genvar gi;
	generate
		for (gi = 0; gi < `HSPL_PIN_COUNT; gi = gi + 1) begin : g_pin_sync
			reg stage1;
			reg stage2;
			reg stage3;
			reg settled;
			// a change counts only once stages two and three agree, so a
			// one-cycle glitch that slips past stage one is dropped
			always @(posedge clk_i) begin
				if (rst_i) begin
					stage1 <= PIN_IDLE[gi];
					stage2 <= PIN_IDLE[gi];
					stage3 <= PIN_IDLE[gi];
					settled <= PIN_IDLE[gi];
				end else begin
					stage1 <= pin_raw[gi];
					stage2 <= stage1;
					stage3 <= stage2;
					if (stage2 == stage3) begin
						settled <= stage2;
					end
				end
			end
			assign pin_stable[gi] = settled;
		end
	endgenerate

	wire ext_rst_n_s = pin_stable[`HSPL_PIN_EXT_RST];
	wire [3:0] oc_n_s = pin_stable[`HSPL_PIN_OC_MSB:`HSPL_PIN_OC_LSB];

	// ======================================================================
	// strap latch at external reset release
	reg ext_rst_n_d;
	reg latched;
	reg [1:0] fixed_port_code;
	reg [1:0] cfg_sel;
	reg [2:0] ctrl;
	reg [4:0] irq_stat;
	reg [4:0] irq_mask;
	reg [3:0] oc_prev;
	wire release_edge = ext_rst_n_s & ~ext_rst_n_d;

	// the release edge comes from the synchronised pin, so all straps are
	// read from one settled snapshot; the selects then stay put until the
	// next release, however the shared pins move afterwards
	always @(posedge clk_i) begin
		if (rst_i) begin
			ext_rst_n_d <= 1'b0;
			latched <= 1'b0;
			fixed_port_code <= `HSPL_FIX_NONE;
			cfg_sel <= 2'h0;
		end else begin
			ext_rst_n_d <= ext_rst_n_s;
			if (!ext_rst_n_s) begin
				latched <= 1'b0;
			end else if (release_edge) begin
				latched <= 1'b1;
				cfg_sel <= pin_stable[`HSPL_PIN_SEL_MSB:`HSPL_PIN_SEL_LSB];
				if (ctrl[`HSPL_CTRL_STRAP_EN]) begin
					fixed_port_code <= pin_stable[`HSPL_PIN_STRAP_MSB:`HSPL_PIN_STRAP_LSB];
				end else begin
					fixed_port_code <= `HSPL_FIX_NONE;
				end
			end
		end
	end

	// ======================================================================
	// pin drive and decoded outputs
	// both enables drop within a cycle of the synchronised pin going low again, handing
	// the shared pins back to the straps well before the next capture
	always @(posedge clk_i) begin
		if (rst_i) begin
			upstream_speed_indicator_o <= 1'b0;
			upstream_speed_indicator_oe_o <= 1'b0;
			suspend_state_indicator_o <= 1'b0;
			suspend_state_indicator_oe_o <= 1'b0;
			config_method_o <= 2'h0;
			fixed_ports_o <= 4'h0;
			port_overcurrent_o <= 4'h0;
		end else begin
			upstream_speed_indicator_oe_o <= latched & ext_rst_n_s;
			suspend_state_indicator_oe_o <= latched & ext_rst_n_s;
			upstream_speed_indicator_o <= ctrl[`HSPL_CTRL_HS] ^ cfg_sel[1];
			// low-active for codes 01 and 11
			suspend_state_indicator_o <= ctrl[`HSPL_CTRL_ACTIVE] ^ fixed_port_code[0];
			config_method_o <= cfg_sel;
			fixed_ports_o <= hspl_fixed_mask(fixed_port_code);
			port_overcurrent_o <= ~oc_n_s;
		end
	end

	// ======================================================================
	// wishbone slave, one-cycle ack, reads of the status word clear it
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire rd_stat = req & ~wb_we_i & (wb_adr_i == `HSPL_ADDR_IRQ_STAT);
	// onset is a high-to-low step of the synchronised sense input; a port
	// that is already in over-current when reset ends raises an event once its input settles low
	wire [3:0] oc_onset = ~oc_n_s & oc_prev;
	wire [4:0] irq_events = {release_edge, oc_onset};

	// the ack is registered: a request seen at one edge is answered at the
	// next, and the ~ack term keeps a held request from being taken twice

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			ctrl <= `HSPL_CTRL_RESET;
			irq_stat <= `HSPL_IRQ_RESET;
			irq_mask <= `HSPL_IRQ_RESET;
			oc_prev <= 4'h0;
			irq_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
			oc_prev <= oc_n_s;
			// new events win over the read clear
			irq_stat <= (rd_stat ? 5'h00 : irq_stat) | irq_events;
			irq_o <= |(irq_stat & irq_mask);
			if (req && wb_we_i && wb_sel_i[0]) begin
				case (wb_adr_i)
					`HSPL_ADDR_CTRL: ctrl <= wb_dat_i[2:0];
					`HSPL_ADDR_IRQ_MASK: irq_mask <= wb_dat_i[4:0];
					default: ;
				endcase
			end
			if (req && !wb_we_i) begin
				case (wb_adr_i)
					`HSPL_ADDR_STRAP: wb_dat_o <= {22'h000000, port_overcurrent_o,
						cfg_sel, fixed_port_code, latched, 1'b0};
					`HSPL_ADDR_CTRL: wb_dat_o <= {29'h00000000, ctrl};
					`HSPL_ADDR_IRQ_STAT: wb_dat_o <= {27'h0000000, irq_stat};
					`HSPL_ADDR_IRQ_MASK: wb_dat_o <= {27'h0000000, irq_mask};
					default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

endmodule // hspl_top
`default_nettype wire

// *** test/hspl_chk_sva.sv ***
// property checker for the strap latch and indicator ports
`timescale 1ns/1ps
`default_nettype none
module hspl_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ext_reset_n_i,
	input wire logic config_method_sel_lo_i,
	input wire logic config_method_sel_hi_i,
	input wire logic [3:0] port_overcurrent_sense_n_i,
	input wire logic upstream_speed_indicator_o,
	input wire logic upstream_speed_indicator_oe_o,
	input wire logic suspend_state_indicator_o,
	input wire logic [1:0] config_method_o,
	input wire logic [3:0] fixed_ports_o,
	input wire logic [3:0] port_overcurrent_o,
	input wire logic wb_ack_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// pin rise held long enough to pass the three-stage synchroniser
	sequence release_s;
		$rose(ext_reset_n_i) ##1 ext_reset_n_i [*7];
	endsequence
	// indicators already driven in two successive cycles
	sequence driving_s;
		upstream_speed_indicator_oe_o && $past(upstream_speed_indicator_oe_o);
	endsequence
	cfg_latch_a: assert property (release_s |->
		config_method_o == {config_method_sel_hi_i, config_method_sel_lo_i}) else $error("select not latched");
	cfg_hold_a: assert property (driving_s |-> $stable(config_method_o))
		else $error("select moved");
	fix_code_a: assert property (fixed_ports_o inside {4'h0, 4'h1, 4'h3, 4'h7})
		else $error("bad fixed mask");
	// three sync stages, the settle step and the registered enable take five cycles; the sixth low sample sees it
	oe_quiet_a: assert property (!ext_reset_n_i [*6] |-> !upstream_speed_indicator_oe_o)
		else $error("pin driven in reset");
	oe_drive_a: assert property (release_s |-> upstream_speed_indicator_oe_o)
		else $error("pin not driven");
	// indicator levels move only through a software state write
	spd_cause_a: assert property (driving_s ##0 $changed(upstream_speed_indicator_o) |->
		wb_ack_o || $past(wb_ack_o)) else $error("speed level moved alone");
	sus_cause_a: assert property (driving_s ##0 $changed(suspend_state_indicator_o) |->
		wb_ack_o || $past(wb_ack_o)) else $error("suspend level moved alone");
	oc_follow_a: assert property ($stable(port_overcurrent_sense_n_i) [*5] |->
		port_overcurrent_o == ~port_overcurrent_sense_n_i) else $error("overcurrent mismatch");
endmodule // hspl_chk
bind hspl_top hspl_chk u_chk (.clk_i, .rst_i, .ext_reset_n_i, .config_method_sel_lo_i,
	.config_method_sel_hi_i, .port_overcurrent_sense_n_i, .upstream_speed_indicator_o,
	.upstream_speed_indicator_oe_o, .suspend_state_indicator_o, .config_method_o,
	.fixed_ports_o, .port_overcurrent_o, .wb_ack_o);
`default_nettype wire

// *** test/hspl_board.sv ***
// board model: reset source, strap resistors and current monitors
`timescale 1ns/1ps
`default_nettype none
module hspl_board (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [3:0] cfg_i,
	input wire logic [3:0] oc_i,
	output var logic rst_n_o = 1'b0,
	output var logic [3:0] pins_o = 4'h0,
	output var logic [3:0] oc_n_o = 4'hF
);
	int cnt = 0;
	// straps hold a while after release, then float (shown inverted)
	always @(posedge clk_i) begin
		cnt <= go_i ? 0 : (cnt < 200 ? cnt + 1 : cnt);
		// low 101 full cycles, just over 1 us
		rst_n_o <= cnt > 100;
		pins_o <= cnt < 112 ? cfg_i : ~cfg_i;
		oc_n_o <= ~oc_i;
	end
endmodule // hspl_board
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the strap latch and indicator block
`timescale 1ns/1ps
`default_nettype none
`include "hspl_map.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module testbench;
	logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, go = 0, wb_ack_o, irq_o;
	logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF, cfg = 4'h0, oc = 4'h0, pins, oc_n, fixed_ports_o;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic spd, spd_oe, sus, sus_oe, ext_n;
	logic [1:0] config_method_o;
	logic [3:0] port_overcurrent_o;
	int bad_count = 0, cmp_count = 0;
	initial forever #5 clk_i = ~clk_i;
	hspl_board brd (.clk_i, .go_i(go), .cfg_i(cfg), .oc_i(oc), .rst_n_o(ext_n), .pins_o(pins),
		.oc_n_o(oc_n));
	hspl_top dut (.clk_i, .rst_i, .ext_reset_n_i(ext_n), .fixed_port_strap_hi_i(pins[1]),
		.fixed_port_strap_lo_i(pins[0]), .config_method_sel_lo_i(pins[2]),
		.config_method_sel_hi_i(pins[3]), .port_overcurrent_sense_n_i(oc_n),
		.upstream_speed_indicator_o(spd), .upstream_speed_indicator_oe_o(spd_oe),
		.suspend_state_indicator_o(sus), .suspend_state_indicator_oe_o(sus_oe), .config_method_o,
		.fixed_ports_o, .port_overcurrent_o, .irq_o, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
		.wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o);
	// ================================================================
	// bus cycle: hold the request until ack is seen at an edge
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
		// no local limit: a missing ack is left to the watchdog
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge clk_i);
	endtask
	task automatic t_straps();
		logic en;
		logic [1:0] s, k;
		// the last pass leaves the strap enable off: the code must read 00
		for (int c = 0; c < 5; c++) begin
			en = (c < 4);
			s = c[1:0] | {2{~en}};
			k = en ? s : 2'h0;
			wb(1, `HSPL_ADDR_CTRL, {31'h0, en});
			cfg <= {s, s};
			go <= 1;
			@(posedge clk_i);
			go <= 0;
			repeat (130) @(posedge clk_i);
			`CHK(config_method_o, s)
			`CHK(fixed_ports_o, (4'h1 << k) - 4'h1)
			`CHK({spd, sus}, {s[1], k[0]})
			`CHK(spd_oe & sus_oe, 1'b1)
			wb(1, `HSPL_ADDR_CTRL, {29'h0, 2'h3, en});
			`CHK({spd, sus}, ~{s[1], k[0]})
			wb(0, `HSPL_ADDR_STRAP, 0);
			`CHK(q[9:0], {4'h0, s, k, 2'h2})
		end
		$display("strap test done");
	endtask
	task automatic t_irq();
		wb(0, `HSPL_ADDR_IRQ_STAT, 0);
		`CHK(q[4:0], 5'h10)
		wb(1, `HSPL_ADDR_IRQ_MASK, 32'h1F);
		for (int p = 0; p < 4; p++) begin
			oc <= 4'h1 << p;
			repeat (8) @(posedge clk_i);
			`CHK({irq_o, port_overcurrent_o}, {1'b1, 4'h1 << p})
			wb(0, `HSPL_ADDR_IRQ_STAT, 0);
			`CHK(q[4:0], 5'h01 << p)
		end
		// masked onset stays quiet yet is still recorded
		wb(1, `HSPL_ADDR_IRQ_MASK, 32'h0);
		oc <= 4'h1;
		repeat (8) @(posedge clk_i);
		`CHK(irq_o, 1'b0)
		wb(0, `HSPL_ADDR_IRQ_STAT, 0);
		`CHK(q[4:0], 5'h01)
		wb(0, 4'h6, 32'h0);
		`CHK(q, 32'h0)
		$display("interrupt test done");
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		t_straps();
		t_irq();
		conclude();
	end
	// hang guard, several times the expected run
	initial begin
		repeat (5000) @(posedge clk_i);
		bad_count++;
		conclude();
	end
endmodule // testbench
`default_nettype wire
